// ==== arcs_defines.svh ====
/*
 shared constants for the repeat capture sequencer and its transfer controller end.
 assumes inclusion by bare name from every design file; definitions only.
*/
`ifndef ARCS_DEFINES_SVH
`define ARCS_DEFINES_SVH

// mode control byte field positions
`define ARCS_MODE_RUN_BIT 7
`define ARCS_MODE_CHSEL_BIT 6
`define ARCS_MODE_CMP_EN_BIT 0
`define ARCS_MODE_RESET 8'h00

// mask group byte: conversion-end mask in bit 0, set at reset (servicing off)
`define ARCS_MASK_BIT 0
`define ARCS_MASK_RESET 8'h01

// limits that let every result pass
`define ARCS_UPPER_RESET 8'hFF
`define ARCS_LOWER_RESET 8'h00

// conversion clock divider, cycles of conversion clock per conversion and per hardware wait
`define ARCS_CLK_DIV 4'h8
`define ARCS_CONV_TICKS 6'h16
`define ARCS_HW_WAIT_TICKS 6'h02

// result alignment: 10-bit value left-aligned in 16 bits
`define ARCS_RES_BITS 10
`define ARCS_RES_SHIFT 6

// channel codes of select mode
`define ARCS_CH_AIN3 5'h03
`define ARCS_CH_AIN16 5'h10
`define ARCS_CH_AMP 5'h17
`define ARCS_CH_TEMP 5'h00
`define ARCS_CH_VREF 5'h01

// transfer controller defaults
`define ARCS_XFER_COUNT 4'h8
`define ARCS_SRC_ADDR 20'hFFF1E
`define ARCS_DST_BASE 20'hFF900
`define ARCS_BLOCK_BYTES 20'h00002

`endif

// ==== arcs_pkg.sv ====
/*
 types of the converter end of the capture sequencer, also used by the testbench.
 assumes arcs_defines.svh is available for the numeric constants.
*/
package arcs_pkg;
  typedef enum logic [1:0]
  {
    ARCS_TRIG_SW,
    ARCS_TRIG_HW_NOWAIT,
    ARCS_TRIG_HW_WAIT
  } arcs_trig_t;
endpackage

// ==== arcs_link_if.sv ====
/*
 link between the converter end and the transfer controller end.
 assumes a single shared clock; the testbench instantiates and joins both ends.
*/
`timescale 1ns/10ps
interface arcs_link_if;
  logic conv_end;
  logic [15:0] result;
  logic xfer_enable;
  logic irq_req;

  modport converter
  (
    output conv_end,
    output result,
    input xfer_enable,
    output irq_req
  );

  modport controller
  (
    input conv_end,
    input result,
    output xfer_enable,
    input irq_req
  );
endinterface

// ==== arcs_transfer_ctrl.sv ====
/*
 transfer controller end: copies the result of each end while activated into an eight-entry
 repeat area and hands the eighth conversion-end on to the cpu request path.
 assumes one clock, async active-high reset, converter end on the same clock.
*/
`timescale 1ns/10ps
`include "arcs_defines.svh"
module arcs_transfer_ctrl #(
  parameter int DEPTH = 8
)
(
  input wire logic clock,
  input wire logic rst,
  arcs_link_if.controller link,
  input wire logic activation_enable,
  input wire logic [2:0] rd_index,
  output logic [15:0] rd_data,
  output logic [19:0] next_dst_addr,
  output logic [3:0] remaining_q,
  output logic active_q
);
  logic [15:0] ram_q [DEPTH];
  logic [2:0] idx_q;
  logic [3:0] count_q;
  logic act_q;
  logic [15:0] rd_q;
  logic [19:0] dst_q;

  // activation gate: cleared after the last transfer, re-armed by software
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      act_q <= 1'b0;
    else if (activation_enable)
      act_q <= 1'b1;
    else if (act_q && link.conv_end && count_q == 4'h1)
      act_q <= 1'b0;
  end

  // fixed source, repeat destination area, one 2-byte entry per transfer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      idx_q <= 3'h0;
      count_q <= `ARCS_XFER_COUNT;
      dst_q <= `ARCS_DST_BASE;
    end
    else if (act_q && link.conv_end)
    begin
      if (count_q == 4'h1)
      begin
        idx_q <= 3'h0;
        count_q <= `ARCS_XFER_COUNT;
        dst_q <= `ARCS_DST_BASE;
      end
      else
      begin
        idx_q <= idx_q + 3'h1;
        count_q <= count_q - 4'h1;
        dst_q <= dst_q + `ARCS_BLOCK_BYTES;
      end
    end
  end

  // repeat area storage; kept out of the reset process, ram cells have no reset
  always_ff @(posedge clock)
  begin
    if (act_q && link.conv_end)
      ram_q[idx_q] <= link.result;
  end

  // registered read port of the repeat area
  always_ff @(posedge clock)
    rd_q <= ram_q[rd_index];

  // enable to converter drops before the eighth end, so that end is both
  // transferred here and flagged to the cpu; when low, ends reach the cpu
  assign link.xfer_enable = act_q && count_q != 4'h1;
  assign rd_data = rd_q;
  assign next_dst_addr = dst_q;
  assign remaining_q = count_q;
  assign active_q = act_q;
endmodule

// ==== arcs_converter.sv ====
/*
 converter control end: mode register, /8 conversion clock, sequential
 single-channel conversions, left-aligned result, limit check, end request.
 assumes one clock at 50 MHz, async active-high reset, the analog sample
 arriving as a parallel word on the same clock, and the transfer controller
 end joined through arcs_link_if.
*/
// Function
// - request flag reads pending conversion-end request
// - mask bit zero allows servicing, one blocks
// - run bit seven starts and stops conversion
// - software trigger: run reads one while converting
// - hardware wait: run reads one incl stabilization
// - select mode converts exactly one chosen input
// - sequential mode restarts automatically until stopped; the code restarts only under software trigger, hardware modes wait for the pin
// - each end stores result, emits end signal
// - result left-aligned, shift six gives value
// - each end signal activates a transfer
// - repeat mode, fixed source, eight 2-byte transfers
// - destination steps entries, wraps to base
// - cpu request only after eighth transfer; the code also requests on every end while activation is off
// - handler re-enables activation, aligns results
// - end signal only within lower and upper limits
// - conversion clock is clock divided by eight
// - select mode at zero, scan at one; the code has no scan, one refuses to convert and flags a channel error
// - sequential at zero, one-shot at one
// - comparator enable bit zero must be set
`timescale 1ns/10ps
`include "arcs_defines.svh"
module arcs_converter
(
  input wire logic clock,
  input wire logic rst,
  arcs_link_if.converter link,
  input wire logic mode_wr,
  input wire logic [7:0] mode_wdata,
  input wire logic mask_wr,
  input wire logic [7:0] mask_wdata,
  input wire logic flag_clr,
  input wire logic one_shot_sel,
  input wire arcs_pkg::arcs_trig_t trig_mode,
  input wire logic hw_trigger,
  input wire logic [4:0] channel_sel,
  input wire logic internal_sel,
  input wire logic [7:0] upper_limit,
  input wire logic [7:0] lower_limit,
  input wire logic [9:0] analog_sample,
  output logic [7:0] mode_rdata,
  output logic [7:0] mask_rdata,
  output logic [15:0] conversion_result,
  output logic conv_done_request_flag,
  output logic cpu_irq,
  output logic channel_error
);
  typedef enum logic [1:0]
  {
    ARCS_IDLE,
    ARCS_STAB,
    ARCS_CONV
  } arcs_state_t;

  arcs_state_t state_q;
  logic [7:0] mode_q;
  logic [7:0] mask_q;
  logic [3:0] div_q;
  logic tick_q;
  logic [5:0] tcnt_q;
  logic [15:0] result_q;
  logic end_q;
  logic flag_q;
  logic irq_q;
  logic chan_err_q;
  logic busy_q;
  logic hw_s1_q;
  logic hw_s2_q;
  logic run;
  logic cmp_en;
  logic chan_ok;
  logic in_limits;
  logic conv_fire;

  assign run = mode_q[`ARCS_MODE_RUN_BIT];
  assign cmp_en = mode_q[`ARCS_MODE_CMP_EN_BIT];
  // legal select-mode channels; scan mode is not supported by this core
  always_comb
  begin
    chan_ok = 1'b0;
    if (!mode_q[`ARCS_MODE_CHSEL_BIT])
    begin
      if (internal_sel)
        chan_ok = (channel_sel == `ARCS_CH_TEMP) || (channel_sel == `ARCS_CH_VREF);
      else
        chan_ok = (channel_sel <= `ARCS_CH_AIN3) ||
          ((channel_sel >= `ARCS_CH_AIN16) && (channel_sel <= `ARCS_CH_AMP));
    end
  end

  // limits compare against the upper eight bits of the result
  assign in_limits = (lower_limit <= analog_sample[9:2]) &&
    (analog_sample[9:2] <= upper_limit);
  assign conv_fire = state_q == ARCS_CONV && tick_q && tcnt_q == 6'h01;

  // mode register; run self-clears after a one-shot conversion
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      mode_q <= `ARCS_MODE_RESET;
    else if (mode_wr)
      mode_q <= mode_wdata;
    else if (conv_fire && one_shot_sel)
      mode_q[`ARCS_MODE_RUN_BIT] <= 1'b0;
  end

  // mask register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      mask_q <= `ARCS_MASK_RESET;
    else if (mask_wr)
      mask_q <= mask_wdata;
  end
  // hardware trigger pin synchroniser
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hw_s1_q <= 1'b0;
      hw_s2_q <= 1'b0;
    end
    else
    begin
      hw_s1_q <= hw_trigger;
      hw_s2_q <= hw_s1_q;
    end
  end

  // conversion clock enable: one pulse every eight clocks
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div_q <= 4'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= div_q == (`ARCS_CLK_DIV - 4'h1);
      div_q <= (div_q == (`ARCS_CLK_DIV - 4'h1)) ? 4'h0 : div_q + 4'h1;
    end
  end

  // conversion sequencer; clearing run or comparator enable aborts at once
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ARCS_IDLE;
      tcnt_q <= 6'h00;
    end
    else if (!run || !cmp_en || !chan_ok)
      state_q <= ARCS_IDLE;
    else
    begin
      case (state_q)
        ARCS_IDLE:
        begin
          if (trig_mode == arcs_pkg::ARCS_TRIG_SW)
          begin
            state_q <= ARCS_CONV;
            tcnt_q <= `ARCS_CONV_TICKS;
          end
          else if (hw_s2_q)
          begin
            state_q <= (trig_mode == arcs_pkg::ARCS_TRIG_HW_WAIT) ? ARCS_STAB : ARCS_CONV;
            tcnt_q <= (trig_mode == arcs_pkg::ARCS_TRIG_HW_WAIT) ?
              `ARCS_HW_WAIT_TICKS : `ARCS_CONV_TICKS;
          end
        end
        ARCS_STAB:
        begin
          if (tick_q)
          begin
            if (tcnt_q == 6'h01)
            begin
              state_q <= ARCS_CONV;
              tcnt_q <= `ARCS_CONV_TICKS;
            end
            else
              tcnt_q <= tcnt_q - 6'h01;
          end
        end
        ARCS_CONV:
        begin
          if (tick_q)
          begin
            if (tcnt_q == 6'h01)
            begin
              // sequential restarts without a new trigger in software mode
              tcnt_q <= `ARCS_CONV_TICKS;
              if (one_shot_sel || trig_mode != arcs_pkg::ARCS_TRIG_SW)
                state_q <= ARCS_IDLE;
            end
            else
              tcnt_q <= tcnt_q - 6'h01;
          end
        end
        default:
          state_q <= ARCS_IDLE;
      endcase
    end
  end

  // result latch and end pulse; results out of limits raise no end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      result_q <= 16'h0000;
      end_q <= 1'b0;
    end
    else
    begin
      end_q <= conv_fire && in_limits;
      if (conv_fire)
        result_q <= {analog_sample, {`ARCS_RES_SHIFT{1'b0}}};
    end
  end

  // request flag: ends the controller keeps silent are not flagged; set wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      flag_q <= 1'b0;
    else if (end_q && !link.xfer_enable)
      flag_q <= 1'b1;
    else if (flag_clr)
      flag_q <= 1'b0;
  end

  // cpu request one cycle behind the flag, gated by the mask
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= flag_q && !mask_q[`ARCS_MASK_BIT];
  end

  // status flops: setting error and run readback; readback lags one cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      chan_err_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      chan_err_q <= run && !chan_ok;
      busy_q <= run && state_q != ARCS_IDLE;
    end
  end

  // run reads as one while converting; in wait mode also during stabilization
  assign mode_rdata = {busy_q, mode_q[6:0]};
  assign mask_rdata = mask_q;
  assign conversion_result = result_q;
  assign conv_done_request_flag = flag_q;
  assign cpu_irq = irq_q;
  assign channel_error = chan_err_q;
  assign link.conv_end = end_q;
  assign link.result = result_q;
  assign link.irq_req = irq_q;
endmodule

// ==== arcs_link_checker.sv ====
/*
 assertions on the link between converter end and transfer controller end.
 assumes one clock, async high reset, instantiated beside the link.
*/
`timescale 1ns/10ps
module arcs_link_checker
(
  input wire logic clock,
  input wire logic rst,
  input wire logic conv_end,
  input wire logic [15:0] result,
  input wire logic xfer_enable,
  input wire logic irq_req
);
  logic [7:0] gap_q;
  logic seen_q;
  logic [3:0] ends_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // cycles since last end; saturates so long idles stay legal
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
    end
    else if (conv_end)
    begin
      gap_q <= 8'h00;
      seen_q <= 1'b1;
    end
    else if (gap_q != 8'hFF)
      gap_q <= gap_q + 8'h01;
  end

  // ends taken silently by the controller; the eighth also goes to the cpu
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ends_q <= 4'h0;
    else if (!xfer_enable)
      ends_q <= 4'h0;
    else if (conv_end)
      ends_q <= ends_q + 4'h1;
  end

  AST_END_PULSE: assert property (conv_end |=> !conv_end)
    else $error("end pulse too long");
  AST_END_GAP: assert property (conv_end && seen_q |-> gap_q >= 8'hAF)
    else $error("ends too close");
  AST_RES_ALIGN: assert property (result[5:0] == 6'h00)
    else $error("result not left aligned");
  AST_RES_HOLD: assert property (conv_end |=> $stable(result)[*8])
    else $error("result moved after end");
  AST_XFER_BOUND: assert property (xfer_enable |-> ends_q < 4'h7)
    else $error("more than seven silent transfers");
  AST_XFER_DROP: assert property ($fell(xfer_enable) |-> ends_q == 4'h7)
    else $error("controller dropped enable at wrong count");
  AST_IDLE_END_IRQ: assert property (conv_end && !xfer_enable |-> ##2 irq_req)
    else $error("idle end raised no request");
  AST_IRQ_RISE: assert property ($rose(irq_req) |-> !xfer_enable)
    else $error("request while transfers armed");

  cover property (conv_end && xfer_enable);
  cover property ($fell(xfer_enable));
  cover property ($rose(irq_req));
endmodule

// ==== adc_repeat_capture_sequencer_tb.sv ====
/*
 testbench: both ends joined by the link, inputs driven at falling edges.
 assumes the package, link, both design ends and the checker compile first.
*/
`timescale 1ns/10ps
module adc_repeat_capture_sequencer_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic mode_wr = 1'b0, mask_wr = 1'b0, flag_clr = 1'b0, act = 1'b0;
  logic [7:0] wdata = 8'h00, ll = 8'h00, mrd, krd;
  logic [4:0] chan = 5'h00;
  logic [9:0] smp = 10'h3C1;
  logic [2:0] ridx = 3'h0;
  logic [15:0] res, rdd;
  logic [19:0] dst;
  logic flag, irq, cerr;
  logic one_shot = 1'b0, isel = 1'b0, hw = 1'b0, actv;
  logic [7:0] ul = 8'hFF;
  logic [3:0] rem;
  arcs_pkg::arcs_trig_t trig = arcs_pkg::ARCS_TRIG_SW;
  int bad_count = 0;
  int check_count = 0;

  arcs_link_if arcs_link_if_inst();

  arcs_converter arcs_converter_inst
  (
    .clock(clock),
    .rst(rst),
    .link(arcs_link_if_inst.converter),
    .mode_wr(mode_wr),
    .mode_wdata(wdata),
    .mask_wr(mask_wr),
    .mask_wdata(wdata),
    .flag_clr(flag_clr),
    .one_shot_sel(one_shot),
    .trig_mode(trig),
    .hw_trigger(hw),
    .channel_sel(chan),
    .internal_sel(isel),
    .upper_limit(ul),
    .lower_limit(ll),
    .analog_sample(smp),
    .mode_rdata(mrd),
    .mask_rdata(krd),
    .conversion_result(res),
    .conv_done_request_flag(flag),
    .cpu_irq(irq),
    .channel_error(cerr)
  );

  arcs_transfer_ctrl arcs_transfer_ctrl_inst
  (
    .clock(clock),
    .rst(rst),
    .link(arcs_link_if_inst.controller),
    .activation_enable(act),
    .rd_index(ridx),
    .rd_data(rdd),
    .next_dst_addr(dst),
    .remaining_q(rem),
    .active_q(actv)
  );

  arcs_link_checker arcs_link_checker_inst
  (
    .clock(clock),
    .rst(rst),
    .conv_end(arcs_link_if_inst.conv_end),
    .result(arcs_link_if_inst.result),
    .xfer_enable(arcs_link_if_inst.xfer_enable),
    .irq_req(arcs_link_if_inst.irq_req)
  );

  // free-running 50 MHz clock
  always #10 clock = ~clock;

  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  // m high writes mode, low writes mask; one-cycle strobe
  task automatic wr(input logic m, input logic [7:0] d);
    @(negedge clock);
    wdata = d;
    mode_wr = m;
    mask_wr = !m;
    @(negedge clock);
    mode_wr = 1'b0;
    mask_wr = 1'b0;
  endtask

  // bounded wait, longer than two conversions
  task automatic wend(output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 400 && !hit; i++)
    begin
      @(negedge clock);
      hit = arcs_link_if_inst.conv_end;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard, about two and a half times the expected run
  initial
  begin
    #240000;
    bad_count++;
    wrap_up();
  end

  initial
  begin
    logic h;
    logic [15:0] e[8];
    logic [7:0] bad_mode[3];
    bad_mode = '{8'h81, 8'hC1, 8'h80};
    repeat (20) @(negedge clock);
    rst = 1'b0;
    chk(mrd, 8'h00);
    chk(krd, 8'h01);
    chk(flag, 1'b0);
    chk(dst, 20'hFF900);
    wr(1'b0, 8'h00);
    chk(krd, 8'h00);
    $display("reset test done");
    @(negedge clock);
    act = 1'b1;
    @(negedge clock);
    act = 1'b0;
    chk(actv, 1'b1);
    wr(1'b1, 8'h81);
    repeat (3) @(negedge clock);
    chk(mrd, 8'h81);
    for (int k = 0; k < 8; k++)
    begin
      wend(h);
      chk(h, 1'b1);
      e[k] = {smp, 6'h00};
      chk(res, e[k]);
      smp = smp - 10'h07B;
      repeat (3) @(negedge clock);
      chk(dst, 20'hFF900 + 20'((k + 1) % 8 * 2));
      chk(rem, 20'(k == 7 ? 8 : 7 - k));
      chk(flag, 20'(k == 7));
    end
    wend(h);
    repeat (3) @(negedge clock);
    chk(flag, 1'b1);
    chk(irq, 1'b1);
    chk(actv, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      ridx = 3'(k);
      repeat (2) @(negedge clock);
      chk(rdd, e[k]);
    end
    $display("capture test done");
    wr(1'b1, 8'h01);
    repeat (2) @(negedge clock);
    chk(mrd, 8'h01);
    wr(1'b0, 8'h01);
    repeat (2) @(negedge clock);
    chk(irq, 1'b0);
    chk(flag, 1'b1);
    wr(1'b0, 8'h00);
    repeat (2) @(negedge clock);
    chk(irq, 1'b1);
    flag_clr = 1'b1;
    @(negedge clock);
    flag_clr = 1'b0;
    @(negedge clock);
    chk(flag, 1'b0);
    $display("request test done");
    // result below lower limit: stored, but no end signal
    ll = 8'hF0;
    smp = 10'h010;
    wr(1'b1, 8'h81);
    wend(h);
    chk(h, 1'b0);
    chk(res, 16'h0400);
    chk(flag, 1'b0);
    wr(1'b1, 8'h01);
    // result above upper limit: no end signal either
    ll = 8'h00;
    ul = 8'h03;
    wr(1'b1, 8'h81);
    wend(h);
    chk(h, 1'b0);
    wr(1'b1, 8'h01);
    ul = 8'hFF;
    $display("limit test done");
    // one-shot on the internal reference: one end, then run drops by itself
    one_shot = 1'b1;
    isel = 1'b1;
    chan = 5'h01;
    wr(1'b1, 8'h81);
    wend(h);
    chk(h, 1'b1);
    chk(res, 16'h0400);
    repeat (3) @(negedge clock);
    chk(mrd, 8'h01);
    wend(h);
    chk(h, 1'b0);
    one_shot = 1'b0;
    isel = 1'b0;
    chan = 5'h00;
    $display("one-shot test done");
    // hardware wait mode: idle until the pin, busy during the wait, idle again after the end
    trig = arcs_pkg::ARCS_TRIG_HW_WAIT;
    wr(1'b1, 8'h81);
    repeat (3) @(negedge clock);
    chk(mrd, 8'h01);
    hw = 1'b1;
    repeat (3) @(negedge clock);
    hw = 1'b0;
    repeat (2) @(negedge clock);
    chk(mrd, 8'h81);
    wend(h);
    chk(h, 1'b1);
    repeat (2) @(negedge clock);
    chk(mrd, 8'h01);
    wend(h);
    chk(h, 1'b0);
    wr(1'b1, 8'h00);
    trig = arcs_pkg::ARCS_TRIG_SW;
    $display("trigger test done");
    // illegal channel, scan mode, comparator off: all refused
    for (int k = 0; k < 3; k++)
    begin
      chan = k == 0 ? 5'h05 : 5'h00;
      wr(1'b1, bad_mode[k]);
      wend(h);
      chk(h, 1'b0);
      if (k == 0)
        chk(cerr, 1'b1);
      wr(1'b1, 8'h00);
    end
    $display("refusal test done");
    wrap_up();
  end
endmodule
